//--- logic/fskcid_pkg.sv
`default_nettype none
package fskcid_pkg;

  // ----------------------------------------------------------------
  // Clock and tone figures.
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned F_MARK_BELL   = 1200;
  localparam int unsigned F_SPACE_BELL  = 2200;
  localparam int unsigned F_MARK_V23    = 1300;
  localparam int unsigned F_SPACE_V23   = 2100;
  localparam int unsigned F_LOW_LIMIT   = 900;
  localparam int unsigned F_HIGH_LIMIT  = 2600;
  localparam int unsigned BAUD_NOM      = 1200;

  // ----------------------------------------------------------------
  // Times in microseconds, as printed, and the chosen working points.
  // ----------------------------------------------------------------
  localparam int unsigned T_PWRUP_MAX_US  = 50000;
  localparam int unsigned T_PWRUP_US      = 40000;
  localparam int unsigned T_PWRDN_MAX_US  = 1000;
  localparam int unsigned T_CD_ON_MAX_US  = 25000;
  localparam int unsigned T_CD_OFF_MIN_US = 8000;
  localparam int unsigned T_CD_OFF_US     = 10000;
  localparam int unsigned T_AL_ON_MIN_US  = 500;
  localparam int unsigned T_AL_ON_MAX_US  = 10000;
  localparam int unsigned T_AL_ON_US      = 5000;
  localparam int unsigned T_AL_OFF_MIN_US = 100;
  localparam int unsigned T_AL_OFF_MAX_US = 8000;
  localparam int unsigned T_AL_OFF_US     = 4000;
  localparam int unsigned CYC_PER_US      = CLK_HZ / 1_000_000;

  // ----------------------------------------------------------------
  // Cycle counts derived from the times and rates.
  // ----------------------------------------------------------------
  localparam int unsigned PWRUP_CYC_DEF  = T_PWRUP_US * CYC_PER_US;
  localparam int unsigned CD_OFF_CYC_DEF = T_CD_OFF_US * CYC_PER_US;
  localparam int unsigned AL_ON_CYC_DEF  = T_AL_ON_US * CYC_PER_US;
  localparam int unsigned AL_OFF_CYC_DEF = T_AL_OFF_US * CYC_PER_US;
  localparam int unsigned BIT_CYC_DEF    = CLK_HZ / BAUD_NOM;
  localparam int unsigned HALF_BIT_DEF   = BIT_CYC_DEF / 2;
  localparam int unsigned THR_BELL       = CLK_HZ / (2 * F_MARK_BELL) + CLK_HZ / (2 * F_SPACE_BELL);
  localparam int unsigned THR_V23        = CLK_HZ / (2 * F_MARK_V23) + CLK_HZ / (2 * F_SPACE_V23);
  localparam int unsigned PER_MIN        = CLK_HZ / F_HIGH_LIMIT;
  localparam int unsigned PER_MAX        = CLK_HZ / F_LOW_LIMIT;
  localparam int unsigned CD_HITS        = 10;
  localparam int          CNT_W          = 24;
  localparam int          PER_W          = 16;
  localparam int          NSYNC          = 6;

  // Positions of the pin inputs inside the synchroniser vector.
  localparam int SY_LINE = 0;
  localparam int SY_ALRT = 1;
  localparam int SY_MODE = 2;
  localparam int SY_V23  = 3;
  localparam int SY_PDN  = 4;
  localparam int SY_SCLK = 5;

  typedef enum logic [1:0] {FSKCID_OFF, FSKCID_WARM, FSKCID_ON} fskcid_pwr_t;

  // Longer period means lower tone, which is the mark (one).
  function automatic logic fskcid_classify(input logic [PER_W-1:0] per, input logic v23);
    fskcid_classify = (per >= (v23 ? PER_W'(THR_V23) : PER_W'(THR_BELL)));
  endfunction : fskcid_classify

  // A period is keyed data only inside the band of both standards.
  function automatic logic fskcid_in_band(input logic [PER_W-1:0] per);
    fskcid_in_band = (per >= PER_W'(PER_MIN)) && (per <= PER_W'(PER_MAX));
  endfunction : fskcid_in_band

endpackage : fskcid_pkg
`default_nettype wire

//--- logic/fskcid_core.sv
`timescale 1ns/10ps
`default_nettype none
module fskcid_core
  import fskcid_pkg::*;
#(
  parameter int unsigned PWRUP_CYC  = PWRUP_CYC_DEF,
  parameter int unsigned CD_OFF_CYC = CD_OFF_CYC_DEF,
  parameter int unsigned AL_ON_CYC  = AL_ON_CYC_DEF,
  parameter int unsigned AL_OFF_CYC = AL_OFF_CYC_DEF,
  parameter int unsigned BIT_CYC    = BIT_CYC_DEF,
  parameter int unsigned HALF_BIT   = HALF_BIT_DEF
) (
  input  wire logic clk_sys,             // System clock, 20 MHz.
  input  wire logic rst_b,               // Asynchronous reset, active low.
  input  wire logic line_fsk,            // Sliced keyed line signal.
  input  wire logic alert_tone,          // Raw dual-tone detector level.
  input  wire logic mode_clocked,        // High selects host-clocked output.
  input  wire logic std_v23,             // High selects V.23 tones.
  input  wire logic power_down,          // High requests low power.
  input  wire logic host_shift_clock,    // Host shift clock.
  output logic      data_out,            // Recovered data bit.
  output logic      bit_ready_strobe_n,  // Bit ready, active low.
  output logic      carrier_present_n,   // Carrier detect, active low.
  output logic      alert_present_n,     // Alert tone present, active low.
  output logic      powered              // High when fully operational.
);

  // ----------------------------------------------------------------
  // Input synchronisers.
  // ----------------------------------------------------------------
  logic [NSYNC-1:0] meta_q;
  logic [NSYNC-1:0] sync_q;
  logic [NSYNC-1:0] prev_q;
  logic             line_rise;
  logic             sclk_rise;
  logic             active;

  // Two flops per pin; the third copy feeds the edge detectors.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= {host_shift_clock, power_down, std_v23, mode_clocked, alert_tone, line_fsk};
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign line_rise = sync_q[SY_LINE] && !prev_q[SY_LINE];
  assign sclk_rise = sync_q[SY_SCLK] && !prev_q[SY_SCLK];

  // ----------------------------------------------------------------
  // Power sequencing.
  // ----------------------------------------------------------------
  fskcid_pwr_t      pwr_q;
  logic [CNT_W-1:0] warm_q;

  // Power-down takes effect at once; wake-up waits the settling time.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pwr_q  <= FSKCID_WARM;
      warm_q <= '0;
    end else begin
      case (pwr_q)
        FSKCID_OFF: begin
          warm_q <= '0;
          if (!sync_q[SY_PDN]) pwr_q <= FSKCID_WARM;
        end
        FSKCID_WARM: begin
          warm_q <= warm_q + CNT_W'(1);
          if (sync_q[SY_PDN]) pwr_q <= FSKCID_OFF;
          else if (warm_q >= CNT_W'(PWRUP_CYC - 1)) pwr_q <= FSKCID_ON;
        end
        FSKCID_ON: begin
          if (sync_q[SY_PDN]) pwr_q <= FSKCID_OFF;
        end
        default: pwr_q <= FSKCID_OFF;
      endcase
    end
  end

  assign active = (pwr_q == FSKCID_ON);

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) powered <= 1'b0;
    else        powered <= active && !sync_q[SY_PDN];
  end

  // ----------------------------------------------------------------
  // Tone demodulator.
  // ----------------------------------------------------------------
  logic [PER_W-1:0] per_q;
  logic             tone_q;
  logic             valid_q;

  // Measures the line period between rising edges and decides the tone.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      per_q   <= '0;
      tone_q  <= 1'b1;
      valid_q <= 1'b0;
    end else begin
      valid_q <= 1'b0;
      if (!active) begin
        per_q  <= '0;
        tone_q <= 1'b1;
      end else if (line_rise) begin
        per_q <= PER_W'(1);
        if (fskcid_in_band(per_q)) begin
          tone_q  <= fskcid_classify(per_q, sync_q[SY_V23]);
          valid_q <= 1'b1;
        end
      end else if (per_q != '1) begin
        per_q <= per_q + PER_W'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // Carrier detect with hysteresis.
  // ----------------------------------------------------------------
  logic [3:0]       hits_q;
  logic [CNT_W-1:0] miss_q;

  // Eleven in-band periods assert carrier; a long silence releases it.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      hits_q            <= '0;
      miss_q            <= '0;
      carrier_present_n <= 1'b1;
    end else if (!active) begin
      hits_q            <= '0;
      miss_q            <= '0;
      carrier_present_n <= 1'b1;
    end else if (valid_q) begin
      miss_q <= '0;
      if (hits_q != 4'(CD_HITS)) hits_q <= hits_q + 4'd1;
      else carrier_present_n <= 1'b0;
    end else if (miss_q >= CNT_W'(CD_OFF_CYC - 1)) begin
      hits_q            <= '0;
      carrier_present_n <= 1'b1;
    end else begin
      miss_q <= miss_q + CNT_W'(1);
      if (carrier_present_n && (per_q > PER_W'(PER_MAX))) hits_q <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Dual-tone alert qualification.
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] al_cnt_q;

  // The detector level must equal the active-low flag for the whole window.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      al_cnt_q        <= '0;
      alert_present_n <= 1'b1;
    end else if (!active || (sync_q[SY_ALRT] != alert_present_n)) begin
      al_cnt_q        <= '0;
      alert_present_n <= active ? alert_present_n : 1'b1;
    end else if (alert_present_n && al_cnt_q >= CNT_W'(AL_ON_CYC - 1)) begin
      al_cnt_q        <= '0;
      alert_present_n <= 1'b0;
    end else if (!alert_present_n && al_cnt_q >= CNT_W'(AL_OFF_CYC - 1)) begin
      al_cnt_q        <= '0;
      alert_present_n <= 1'b1;
    end else begin
      al_cnt_q <= al_cnt_q + CNT_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // Bit timing and output.
  // ----------------------------------------------------------------
  logic             tone_prev_q;
  logic [PER_W-1:0] baud_q;
  logic [PER_W-1:0] strb_q;
  logic             mid_bit;

  assign mid_bit = (baud_q == PER_W'(1));

  // Each tone change re-centres the bit timer, so rate drift is absorbed.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tone_prev_q <= 1'b1;
      baud_q      <= PER_W'(HALF_BIT);
    end else begin
      tone_prev_q <= tone_q;
      if (tone_q != tone_prev_q) baud_q <= PER_W'(HALF_BIT);
      else if (mid_bit) baud_q <= PER_W'(BIT_CYC);
      else baud_q <= baud_q - PER_W'(1);
    end
  end

  // Strobe falls at mid bit and rises on a shift clock or after half a bit.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      bit_ready_strobe_n <= 1'b1;
      strb_q             <= '0;
      data_out           <= 1'b1;
    end else if (!active) begin
      bit_ready_strobe_n <= 1'b1;
      strb_q             <= '0;
      data_out           <= 1'b1;
    end else if (!sync_q[SY_MODE]) begin
      bit_ready_strobe_n <= 1'b1;
      strb_q             <= '0;
      data_out           <= tone_q;
    end else if (mid_bit && !carrier_present_n) begin
      bit_ready_strobe_n <= 1'b0;
      strb_q             <= '0;
      data_out           <= tone_q;
    end else if (!bit_ready_strobe_n) begin
      strb_q <= strb_q + PER_W'(1);
      if (sclk_rise || strb_q >= PER_W'(HALF_BIT - 1)) bit_ready_strobe_n <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  sequence s_strobe_fall;
    $fell(bit_ready_strobe_n);
  endsequence
  sequence s_strobe_released;
    bit_ready_strobe_n;
  endsequence
  sequence s_shift_seen;
    !bit_ready_strobe_n && sclk_rise && !mid_bit && active && sync_q[SY_MODE];
  endsequence

  property p_bell_tone;
    (active && line_rise && fskcid_in_band(per_q) && !sync_q[SY_V23])
      |=> tone_q == (($past(per_q)) >= PER_W'(THR_BELL));
  endproperty
  a_bell_tone: assert property (p_bell_tone) else $error("Bell tone decision wrong");

  property p_v23_tone;
    (active && line_rise && fskcid_in_band(per_q) && sync_q[SY_V23])
      |=> tone_q == (($past(per_q)) >= PER_W'(THR_V23));
  endproperty
  a_v23_tone: assert property (p_v23_tone) else $error("V.23 tone decision wrong");

  property p_resync;
    (tone_q != tone_prev_q) |=> baud_q == PER_W'(HALF_BIT);
  endproperty
  a_resync: assert property (p_resync) else $error("Bit timer not re-centred");

  property p_pwr_down;
    sync_q[SY_PDN] |=> !active ##1 !powered;
  endproperty
  a_pwr_down: assert property (p_pwr_down) else $error("Power-down too slow");

  property p_pwr_up;
    $rose(active) |-> $past(warm_q) == CNT_W'(PWRUP_CYC - 1);
  endproperty
  a_pwr_up: assert property (p_pwr_up) else $error("Wake-up time wrong");

  property p_cd_on;
    $fell(carrier_present_n) |-> $past(valid_q) && $past(hits_q) == 4'(CD_HITS);
  endproperty
  a_cd_on: assert property (p_cd_on) else $error("Carrier set without qualification");

  property p_cd_off;
    (active && $rose(carrier_present_n)) |-> $past(miss_q) == CNT_W'(CD_OFF_CYC - 1);
  endproperty
  a_cd_off: assert property (p_cd_off) else $error("Carrier released early");

  property p_alert_on;
    $fell(alert_present_n) |-> $past(al_cnt_q) == CNT_W'(AL_ON_CYC - 1);
  endproperty
  a_alert_on: assert property (p_alert_on) else $error("Alert set at wrong time");

  property p_alert_off;
    (active && $rose(alert_present_n)) |-> $past(al_cnt_q) == CNT_W'(AL_OFF_CYC - 1);
  endproperty
  a_alert_off: assert property (p_alert_off) else $error("Alert cleared at wrong time");

  property p_strobe_len;
    !bit_ready_strobe_n |-> strb_q < PER_W'(HALF_BIT);
  endproperty
  a_strobe_len: assert property (p_strobe_len) else $error("Strobe low too long");

  // A shift clock seen while the strobe is low, except at mid bit, releases it on the next edge.
  property p_strobe_clear;
    s_shift_seen |=> s_strobe_released;
  endproperty
  a_strobe_clear: assert property (p_strobe_clear) else $error("Shift clock did not clear");

  // The strobe only falls at mid bit, together with the bit it announces.
  property p_strobe_data;
    s_strobe_fall |-> $past(mid_bit) && (data_out == $past(tone_q));
  endproperty
  a_strobe_data: assert property (p_strobe_data) else $error("Strobe fell off mid bit");

  property p_direct;
    (active && !sync_q[SY_MODE]) |=> data_out == $past(tone_q);
  endproperty
  a_direct: assert property (p_direct) else $error("Direct data not following tone");

endmodule : fskcid_core
`default_nettype wire

//--- tb/fskcid_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// Host controller that collects bits in the clocked mode.
// ----------------------------------------------------------------
module fskcid_host_model (
  input  wire logic enable,              // High lets the host answer strobes.
  input  wire logic slow,                // High makes the host answer late.
  input  wire logic bit_ready_strobe_n,  // Bit ready, active low.
  input  wire logic data_out,            // Recovered data bit.
  output var  logic host_shift_clock,    // Shift clock, idles low.
  output var  int   bits_seen,           // Bits collected so far.
  output var  logic last_bit             // Last bit collected.
);
  // The shift clock stands still low outside a bit transfer.
  initial begin
    host_shift_clock = 1'b0;
    bits_seen        = 0;
    last_bit         = 1'b0;
  end

  // One 200 ns shift clock pulse per falling strobe, data taken at its rise.
  always @(negedge bit_ready_strobe_n) begin
    if (enable === 1'b1) begin
      #(slow ? 2025 : 225);  // Ends on a falling clock edge, never on a sampling edge.
      last_bit         = data_out;
      bits_seen        = bits_seen + 1;
      host_shift_clock = 1'b1;
      #200;
      host_shift_clock = 1'b0;
    end
  end
endmodule : fskcid_host_model
`default_nettype wire

//--- tb/fsk_caller_id_data_output_test.sv
`timescale 1ns/10ps
`default_nettype none
`define FSKCID_CHK(nm, ex, got) \
  begin \
    cmp_count++; \
    if ((got) !== (ex)) begin \
      errors++; \
      $display("mismatch %s expected %0h seen %0h", nm, ex, got); \
    end \
  end
module fsk_caller_id_data_output_test;
  import fskcid_pkg::*;
  // ----------------------------------------------------------------
  // Shortened counts and bench signals.
  // ----------------------------------------------------------------
  localparam int T_PWRUP = 200;
  localparam int T_CDOFF = 25000;
  localparam int T_ALON  = 50;
  localparam int T_ALOFF = 40;
  localparam int T_BIT   = 4000;
  localparam int T_HALF  = 2000;
  logic clk_sys, rst_b, line_fsk, alert_tone, mode_clocked, std_v23, power_down;
  logic host_shift_clock, data_out, bit_ready_strobe_n, carrier_present_n;
  logic alert_present_n, powered, host_en, host_slow, host_bit;
  int   host_bits, errors, cmp_count, low_run, last_low, n;
  int   per_t [9] = '{9091, 16667, 16835, 9001, 16502, 9524, 15385, 9383, 15619};
  int   cnt_t [9] = '{12, 2, 1, 2, 2, 2, 2, 1, 1};
  logic exp_t [9] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};

  fskcid_core #(.PWRUP_CYC(T_PWRUP), .CD_OFF_CYC(T_CDOFF), .AL_ON_CYC(T_ALON),
    .AL_OFF_CYC(T_ALOFF), .BIT_CYC(T_BIT), .HALF_BIT(T_HALF)) dut_u (.clk_sys(clk_sys),
    .rst_b(rst_b), .line_fsk(line_fsk),
    .alert_tone(alert_tone), .mode_clocked(mode_clocked), .std_v23(std_v23),
    .power_down(power_down), .host_shift_clock(host_shift_clock), .data_out(data_out),
    .bit_ready_strobe_n(bit_ready_strobe_n), .carrier_present_n(carrier_present_n),
    .alert_present_n(alert_present_n), .powered(powered));

  fskcid_host_model host_u (.enable(host_en), .slow(host_slow),
    .bit_ready_strobe_n(bit_ready_strobe_n), .data_out(data_out),
    .host_shift_clock(host_shift_clock), .bits_seen(host_bits), .last_bit(host_bit));

  // The clock runs at 20 MHz.
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // Length of the most recent low run of the ready strobe, in cycles.
  always @(posedge clk_sys) begin
    if (bit_ready_strobe_n === 1'b0) begin
      low_run = low_run + 1;
    end else if (low_run != 0) begin
      last_low = low_run;
      low_run  = 0;
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks.
  // ----------------------------------------------------------------
  task conclude;
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude

  function automatic logic pick(input int s);
    case (s)
      0: pick = powered;
      1: pick = alert_present_n;
      default: pick = carrier_present_n;
    endcase
  endfunction : pick

  // Waits a bounded number of cycles for a flag to reach a level.
  task automatic wait_sig(input int s, input logic v, input int lim, output int k);
    k = 0;
    while (pick(s) !== v) begin
      @(negedge clk_sys);
      k++;
      if (k > lim) begin
        errors++;
        $display("mismatch flag%0d expected %0h seen timeout", s, v);
        conclude();
      end
    end
  endtask : wait_sig

  // Sends whole tone periods; each is a low half then a high half, with a rising edge in the middle.
  task automatic tone(input int per, input int cnt);
    repeat (cnt) begin
      line_fsk = 1'b0;
      repeat (per / 2) @(negedge clk_sys);
      line_fsk = 1'b1;
      repeat (per - per / 2) @(negedge clk_sys);
    end
  endtask : tone

  // ----------------------------------------------------------------
  // Scenarios.
  // ----------------------------------------------------------------
  task automatic t_alert;
    alert_tone = 1'b1;
    wait_sig(1, 1'b0, 200, n);
    `FSKCID_CHK("alert_on", 1'b1, (n >= T_ALON && n <= T_ALON + 8));
    alert_tone = 1'b0;
    wait_sig(1, 1'b1, 200, n);
    `FSKCID_CHK("alert_off", 1'b1, (n >= T_ALOFF && n <= T_ALOFF + 8));
    alert_tone = 1'b1;
    repeat (T_ALON / 2) @(negedge clk_sys);
    alert_tone = 1'b0;
    repeat (T_ALON + 10) @(negedge clk_sys);
    `FSKCID_CHK("alert_glitch", 1'b1, alert_present_n);
  endtask : t_alert

  task automatic t_direct;
    mode_clocked = 1'b0;
    last_low     = 0;
    for (int i = 0; i < 9; i++) begin
      std_v23 = (i >= 5);
      tone(per_t[i], cnt_t[i]);
      if (i < 5) begin
        `FSKCID_CHK("bell_bit", exp_t[i], data_out);
      end else begin
        `FSKCID_CHK("v23_bit", exp_t[i], data_out);
      end
      `FSKCID_CHK("carrier_on", 1'b0, carrier_present_n);
    end
    `FSKCID_CHK("strobe_idle", 1'b1, (last_low == 0));
  endtask : t_direct

  task automatic t_clocked;
    int b0;
    std_v23      = 1'b0;
    mode_clocked = 1'b1;
    b0           = host_bits;
    tone(16835, 1);
    `FSKCID_CHK("bits_taken", 1'b1, (host_bits - b0 >= 2));
    `FSKCID_CHK("bit_value", 1'b1, host_bit);
    `FSKCID_CHK("strobe_prompt", 1'b1, (last_low >= 4 && last_low <= 12));
    host_slow = 1'b1;
    tone(16667, 1);
    `FSKCID_CHK("strobe_slow", 1'b1, (last_low >= 40 && last_low <= 50));
    host_en = 1'b0;
    tone(16667, 1);
    n = T_HALF;
    `FSKCID_CHK("strobe_lapse", 1'b1, (last_low >= n - 2 && last_low <= n + 2));
    host_en = 1'b1;
  endtask : t_clocked

  task automatic t_silence;
    line_fsk = 1'b0;
    wait_sig(2, 1'b1, T_CDOFF, n);
    n = n + 16667 - 16667 / 2;
    `FSKCID_CHK("carrier_hold", 1'b1, (n >= T_CDOFF && n <= T_CDOFF + 12));
  endtask : t_silence

  task automatic t_power;
    power_down = 1'b1;
    wait_sig(0, 1'b0, 20, n);
    `FSKCID_CHK("power_down_time", 1'b1, (n <= 10));
    power_down = 1'b0;
    wait_sig(0, 1'b1, T_PWRUP + 20, n);
    `FSKCID_CHK("power_up_time", 1'b1, (n >= T_PWRUP && n <= T_PWRUP + 8));
  endtask : t_power

  // ----------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------
  initial begin
    {rst_b, line_fsk, alert_tone, mode_clocked, std_v23, power_down} = 6'h00;
    {host_en, host_slow} = 2'h2;
    errors    = 0;
    cmp_count = 0;
    low_run   = 0;
    last_low  = 0;
    repeat (12) @(negedge clk_sys);
    rst_b = 1'b1;
    wait_sig(0, 1'b1, T_PWRUP + 20, n);
    `FSKCID_CHK("reset_power_up", 1'b1, (n >= T_PWRUP && n <= T_PWRUP + 8));
    t_alert();
    t_direct();
    t_clocked();
    t_silence();
    t_power();
    conclude();
  end
endmodule : fsk_caller_id_data_output_test
`default_nettype wire
